// ---- scpd_ctrl_model.sv ----
`timescale 1ns/1ps
module scpd_ctrl_model (
  // serial pins
  output logic select_n_o,
  output logic sclk_o,
  output wire  sdio_line_o,
  input  wire  dev_sdio_i,
  input  wire  dev_oe_i
);
  logic d = 1'b0;
  logic own = 1'b0;
  initial select_n_o = 1'b1;
  initial sclk_o = 1'b0;
  // released line shows the inverse of the last bit, never a stale copy
  assign sdio_line_o = dev_oe_i ? dev_sdio_i : (own ? d : ~d);
  task automatic sel(input logic v);
    select_n_o = v;
    #100;
  endtask
  // clock stands low between frames; low 100 ns, high 60 ns
  task automatic shift(input logic [23:0] w, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    for (int i = 0; i < nb; i++) begin
      own = !(w[23] && i >= 16);
      d = w[23 - i];
      #100;
      rd = {rd[6:0], sdio_line_o};
      sclk_o = 1'b1;
      #60;
      sclk_o = 1'b0;
    end
    own = 1'b0;
  endtask
endmodule

// ---- scpd_properties.sv ----
`timescale 1ns/1ps
module scpd_properties (
  // clock and reset
  input wire        sys_clk_i,
  input wire        rst_n_i,
  // pins
  input wire        serial_select_n_i,
  input wire        sclk_i,
  input wire        sdio_oe_o,
  input wire        powerdown_sync_pin_i,
  input wire        sample_clk_present_i,
  input wire [1:0]  reference_select_pin_i,
  // data and controls
  input wire [17:0] ch_b_i,
  input wire        sample_valid_i,
  input wire [17:0] out_b_o,
  input wire        out_valid_o,
  input wire        global_pdn_o,
  input wire        adc_a_pdn_o,
  input wire        adc_b_pdn_o,
  input wire [5:0]  driver_pdn_o,
  input wire [1:0]  ref_mode_o,
  input wire        single_ended_clk_o
);
  // ---
  // properties
  // ---
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence idle_sel;
    serial_select_n_i [*5];
  endsequence
  sequence pin_pd;
    (powerdown_sync_pin_i && sample_clk_present_i) [*5];
  endsequence
  sequence ref_held;
    ($stable(reference_select_pin_i) && sample_clk_present_i) [*5];
  endsequence
  AST_OE_IDLE: assert property (idle_sel |-> !sdio_oe_o)
    else $error("data pin driven while deselected");
  AST_OE_LATE: assert property ($rose(sdio_oe_o) |-> !$past(sclk_i, 2))
    else $error("read data not launched on a falling edge");
  AST_PIN_PDN: assert property (pin_pd |-> global_pdn_o)
    else $error("pin did not power down");
  AST_CH_PDN: assert property (global_pdn_o |-> adc_a_pdn_o && adc_b_pdn_o)
    else $error("channels awake in global power-down");
  AST_PDN_HOLD: assert property (!sample_clk_present_i [*4] |=>
    $stable({global_pdn_o, adc_a_pdn_o, adc_b_pdn_o, driver_pdn_o}))
    else $error("power-down changed without sampling clock");
  AST_VALID: assert property (sample_valid_i |=> out_valid_o && out_b_o == $past(ch_b_i))
    else $error("sample not passed in one cycle");
  AST_NO_VALID: assert property (!sample_valid_i |=> !out_valid_o)
    else $error("spurious output valid");
  AST_REF_MODE: assert property (ref_held |-> ref_mode_o == reference_select_pin_i &&
    single_ended_clk_o == (reference_select_pin_i == 2'h0))
    else $error("reference mode not from pin");
endmodule
bind scpd_top scpd_properties u_scpd_properties (.*);

// ---- scpd_regs.vh ----
// Summary of operation
// [R1] normal mode passes full-scale conversions as 18-bit output words
// [R2] global power-down when register bit set or active-high pin driven high
// [R3] global power-down also powers down both converter channels
// [R4] controller powers down reference amplifier only while already powered down
// [R5] unused output interface drivers can be powered down one by one
// [R6] power-down changes take effect only while sampling clock runs
// [R7] averaging enabled: the two channel results are averaged per sample
// [R8] averaged result goes to channel A lanes or to decimation filter
// [R9] reset values give a usable default with no serial access
// [R10] reference and clock option chosen from reference select pin level
// [R11] bits shift in only while serial select is low
// [R12] one data bit sampled at each rising serial clock edge
// [R13] every 24th rising edge commits a write frame to its register
// [R14] trailing partial frame bits are dropped, no register changes
// [R15] several 24-bit frames per select period, each an independent access
// [R16] serial clock up to 12 MHz, down to hertz, any duty cycle
// [R17] write frame: flag bit 15 clear, bits 14..12 zero, 12-bit address, data byte
// [R18] read frame: register byte driven on falling edges, msb first
// [R19] a read frame never changes any register
// [R20] data pin released whenever read data is not driven
// [R21] raising select clears the bit counter for a fresh frame
`ifndef SCPD_REGS_VH
`define SCPD_REGS_VH
`define SCPD_FRAME_BITS   5'h18
`define SCPD_ADDR_BITS    5'h10
`define SCPD_RW_BIT       15
`define SCPD_ADDR_PDN     15'h0008
`define SCPD_ADDR_DRV     15'h0009
`define SCPD_ADDR_MASK    15'h000D
`define SCPD_ADDR_REF     15'h000E
`define SCPD_ADDR_AVG     15'h0024
`define SCPD_RST_PDN      8'h00
`define SCPD_RST_DRV      8'h00
`define SCPD_RST_MASK     8'h00
`define SCPD_RST_REF      8'h00
`define SCPD_RST_AVG      8'h00
`define SCPD_PDN_GLOBAL   0
`define SCPD_PDN_B        1
`define SCPD_PDN_A        2
`define SCPD_PDN_REFAMP   4
`define SCPD_PDN_CLKBUF   5
`define SCPD_MASK_REFAMP  2
`define SCPD_MASK_CLKBUF  3
`define SCPD_REF_SE       0
`define SCPD_REF_CTRL     3
`define SCPD_AVG_MUX      3
`define SCPD_AVG_EN       5
`define SCPD_LVL_SE_INT   2'h0
`define SCPD_LVL_INT      2'h1
`define SCPD_LVL_GAINBUF  2'h2
`define SCPD_LVL_EXT      2'h3
`endif

// ---- scpd_top.v ----
`timescale 1ns/1ps
`include "scpd_regs.vh"
module scpd_top (
  // clock, reset, enable
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  // serial port
  input  wire        serial_select_n_i,
  input  wire        sclk_i,
  input  wire        sdio_i,
  output reg         sdio_o,
  output reg         sdio_oe_o,
  // pins and clock status
  input  wire        powerdown_sync_pin_i,
  input  wire        sample_clk_present_i,
  input  wire [1:0]  reference_select_pin_i,
  // conversion data
  input  wire [17:0] ch_a_i,
  input  wire [17:0] ch_b_i,
  input  wire        sample_valid_i,
  output reg  [17:0] out_a_o,
  output reg  [17:0] out_b_o,
  output reg         out_valid_o,
  output reg  [17:0] decimation_filter_o,
  output reg         decimation_filter_valid_o,
  // power and reference controls
  output reg         global_pdn_o,
  output reg         adc_a_pdn_o,
  output reg         adc_b_pdn_o,
  output reg         refamp_pdn_o,
  output reg         clkbuf_pdn_o,
  output reg  [5:0]  driver_pdn_o,
  output reg  [1:0]  ref_mode_o,
  output reg         single_ended_clk_o
);

// ----------------------------------------
// input synchronisers
// ----------------------------------------
wire       sel_sync;
wire       clk_sync;
wire       dat_sync;
wire       pin_sync;
wire       run_sync;
wire       lvl0_sync;
wire       lvl1_sync;
reg        clk_prev;

scpd_sync2 #(
  .RESET_VAL (1'b1)
) u_sync_sel (
  .sys_clk_i (sys_clk_i),
  .rst_n_i   (rst_n_i),
  .ce_i      (ce_i),
  .async_i   (serial_select_n_i),
  .sync_o    (sel_sync)
);

scpd_sync2 u_sync_clk (
  .sys_clk_i (sys_clk_i),
  .rst_n_i   (rst_n_i),
  .ce_i      (ce_i),
  .async_i   (sclk_i),
  .sync_o    (clk_sync)
);

scpd_sync2 u_sync_dat (
  .sys_clk_i (sys_clk_i),
  .rst_n_i   (rst_n_i),
  .ce_i      (ce_i),
  .async_i   (sdio_i),
  .sync_o    (dat_sync)
);

scpd_sync2 u_sync_pin (
  .sys_clk_i (sys_clk_i),
  .rst_n_i   (rst_n_i),
  .ce_i      (ce_i),
  .async_i   (powerdown_sync_pin_i),
  .sync_o    (pin_sync)
);

scpd_sync2 u_sync_run (
  .sys_clk_i (sys_clk_i),
  .rst_n_i   (rst_n_i),
  .ce_i      (ce_i),
  .async_i   (sample_clk_present_i),
  .sync_o    (run_sync)
);

scpd_sync2 #(
  .RESET_VAL (1'b1)
) u_sync_lvl0 (
  .sys_clk_i (sys_clk_i),
  .rst_n_i   (rst_n_i),
  .ce_i      (ce_i),
  .async_i   (reference_select_pin_i[0]),
  .sync_o    (lvl0_sync)
);

scpd_sync2 #(
  .RESET_VAL (1'b1)
) u_sync_lvl1 (
  .sys_clk_i (sys_clk_i),
  .rst_n_i   (rst_n_i),
  .ce_i      (ce_i),
  .async_i   (reference_select_pin_i[1]),
  .sync_o    (lvl1_sync)
);

// detector starts at the clock's idle level, so reset makes no false edge
always @(posedge sys_clk_i) begin
  if (!rst_n_i) begin
    clk_prev <= 1'b0;
  end else if (ce_i) begin
    clk_prev <= clk_sync;
  end
end

// select and clock travel the same two-stage path, so their order holds
wire sel_act = ~sel_sync;
wire rise    = clk_sync & ~clk_prev;
wire fall    = ~clk_sync & clk_prev;
wire [1:0] ref_level = {lvl1_sync, lvl0_sync};

// ----------------------------------------
// serial frame engine
// ----------------------------------------
reg  [4:0]  bit_cnt;
reg  [22:0] shift;
reg         rd_active;
reg  [7:0]  rd_shift;
reg  [7:0]  reg_pdn;
reg  [7:0]  reg_drv;
reg  [7:0]  reg_mask;
reg  [7:0]  reg_ref;
reg  [7:0]  reg_avg;
reg  [7:0]  rd_value;

wire [23:0] frame    = {shift, dat_sync};
wire        last_bit = (bit_cnt == `SCPD_FRAME_BITS - 5'h01);
wire        addr_end = (bit_cnt == `SCPD_ADDR_BITS - 5'h01);
wire        commit   = sel_act & rise & last_bit & ~frame[8 + `SCPD_RW_BIT]; // [R13] [R19]
wire [14:0] wr_addr  = frame[22:8]; // [R17]
wire [14:0] rd_addr  = frame[14:0];

// unmapped addresses read back as zero
always @* begin
  case (rd_addr)
    `SCPD_ADDR_PDN:  rd_value = reg_pdn;
    `SCPD_ADDR_DRV:  rd_value = reg_drv;
    `SCPD_ADDR_MASK: rd_value = reg_mask;
    `SCPD_ADDR_REF:  rd_value = reg_ref;
    `SCPD_ADDR_AVG:  rd_value = reg_avg;
    default:         rd_value = 8'h00;
  endcase
end

always @(posedge sys_clk_i) begin
  if (!rst_n_i) begin
    bit_cnt   <= 5'h00;
    shift     <= 23'h000000;
    rd_active <= 1'b0;
    rd_shift  <= 8'h00;
    sdio_o    <= 1'b0;
    sdio_oe_o <= 1'b0;
  end else if (ce_i) begin
    if (!sel_act) begin
      bit_cnt   <= 5'h00; // [R21] [R14]
      rd_active <= 1'b0;
      sdio_oe_o <= 1'b0; // [R20]
    end else begin
      if (rise) begin // [R11] [R12] [R16]
        shift <= frame[22:0];
        if (last_bit) begin
          bit_cnt   <= 5'h00; // [R15]
          rd_active <= 1'b0;
        end else begin
          bit_cnt <= bit_cnt + 5'h01;
        end
        if (addr_end && frame[`SCPD_RW_BIT]) begin
          rd_active <= 1'b1;
          rd_shift  <= rd_value;
        end
      end
      if (fall && rd_active) begin // [R18]
        sdio_o    <= rd_shift[7];
        sdio_oe_o <= 1'b1;
        rd_shift  <= {rd_shift[6:0], 1'b0};
      end else if (!rd_active) begin
        sdio_oe_o <= 1'b0; // [R20]
      end
    end
  end
end

// ----------------------------------------
// configuration registers
// ----------------------------------------
always @(posedge sys_clk_i) begin
  if (!rst_n_i) begin
    reg_pdn  <= `SCPD_RST_PDN; // [R9]
    reg_drv  <= `SCPD_RST_DRV;
    reg_mask <= `SCPD_RST_MASK;
    reg_ref  <= `SCPD_RST_REF;
    reg_avg  <= `SCPD_RST_AVG;
  end else if (ce_i && commit) begin
    case (wr_addr)
      `SCPD_ADDR_PDN:  reg_pdn  <= frame[7:0];
      `SCPD_ADDR_DRV:  reg_drv  <= frame[7:0];
      `SCPD_ADDR_MASK: reg_mask <= frame[7:0];
      `SCPD_ADDR_REF:  reg_ref  <= frame[7:0];
      `SCPD_ADDR_AVG:  reg_avg  <= frame[7:0];
      default:         reg_pdn  <= reg_pdn;
    endcase
  end
end

// ----------------------------------------
// power-down control
// ----------------------------------------
// no sampling clock means the analog side cannot act, so outputs hold
wire glob = reg_pdn[`SCPD_PDN_GLOBAL] | pin_sync; // [R2]

always @(posedge sys_clk_i) begin
  if (!rst_n_i) begin
    global_pdn_o <= 1'b0;
    adc_a_pdn_o  <= 1'b0;
    adc_b_pdn_o  <= 1'b0;
    refamp_pdn_o <= 1'b0;
    clkbuf_pdn_o <= 1'b0;
    driver_pdn_o <= 6'h00;
  end else if (ce_i && run_sync) begin // [R6]
    global_pdn_o <= glob;
    adc_a_pdn_o  <= glob | reg_pdn[`SCPD_PDN_A]; // [R3]
    adc_b_pdn_o  <= glob | reg_pdn[`SCPD_PDN_B]; // [R3]
    // amplifier sequencing is left to the controller
    refamp_pdn_o <= reg_pdn[`SCPD_PDN_REFAMP] |
                    (glob & reg_mask[`SCPD_MASK_REFAMP]); // [R4]
    clkbuf_pdn_o <= reg_pdn[`SCPD_PDN_CLKBUF] |
                    (glob & reg_mask[`SCPD_MASK_CLKBUF]);
    driver_pdn_o <= reg_drv[5:0]; // [R5]
  end
end

// ----------------------------------------
// reference and clock selection
// ----------------------------------------
always @(posedge sys_clk_i) begin
  if (!rst_n_i) begin
    ref_mode_o         <= `SCPD_LVL_EXT;
    single_ended_clk_o <= 1'b0;
  end else if (ce_i) begin
    if (reg_ref[`SCPD_REF_CTRL]) begin
      ref_mode_o         <= reg_ref[2:1];
      single_ended_clk_o <= reg_ref[`SCPD_REF_SE];
    end else begin
      ref_mode_o         <= ref_level; // [R10]
      single_ended_clk_o <= (ref_level == `SCPD_LVL_SE_INT); // [R10]
    end
  end
end

// ----------------------------------------
// data path and averaging
// ----------------------------------------
// sign-extended sum keeps the average free of overflow
wire [18:0] sum    = {ch_a_i[17], ch_a_i} + {ch_b_i[17], ch_b_i};
wire [17:0] avg    = sum[18:1];
wire        avg_en = reg_avg[`SCPD_AVG_EN];
wire        to_flt = reg_avg[`SCPD_AVG_MUX];

always @(posedge sys_clk_i) begin
  if (!rst_n_i) begin
    out_a_o                   <= 18'h00000;
    out_b_o                   <= 18'h00000;
    out_valid_o               <= 1'b0;
    decimation_filter_o       <= 18'h00000;
    decimation_filter_valid_o <= 1'b0;
  end else if (ce_i) begin
    out_valid_o               <= sample_valid_i;
    decimation_filter_valid_o <= sample_valid_i;
    if (sample_valid_i) begin
      out_b_o <= ch_b_i; // [R1]
      if (avg_en && !to_flt) begin
        out_a_o <= avg; // [R7] [R8]
      end else begin
        out_a_o <= ch_a_i; // [R1]
      end
      if (avg_en && to_flt) begin
        decimation_filter_o <= avg; // [R8]
      end else begin
        decimation_filter_o <= ch_a_i;
      end
    end
  end
end

endmodule

// ----------------------------------------
// two-stage synchroniser
// ----------------------------------------
// only the second stage is read outside, the first may be metastable
module scpd_sync2 #(
  parameter [0:0] RESET_VAL = 1'b0
) (
  // clock, reset, enable
  input  wire sys_clk_i,
  input  wire rst_n_i,
  input  wire ce_i,
  // async level in, synced level out
  input  wire async_i,
  output reg  sync_o
);

reg meta;

always @(posedge sys_clk_i) begin
  if (!rst_n_i) begin
    meta   <= RESET_VAL;
    sync_o <= RESET_VAL;
  end else if (ce_i) begin
    meta   <= async_i;
    sync_o <= meta;
  end
end

endmodule

// ---- scpd_top_bench.sv ----
`timescale 1ns/1ps
`include "scpd_regs.vh"
module scpd_top_bench;
  logic        sys_clk_i, rst_n_i, ce_i, powerdown_sync_pin_i, sample_clk_present_i;
  logic        sample_valid_i;
  logic [1:0]  reference_select_pin_i;
  logic [17:0] ch_a_i, ch_b_i, pa, pb;
  logic [15:0] lf = 16'h8E98;
  logic [7:0]  rd;
  wire         serial_select_n_i, sclk_i, sdio_i, sdio_o, sdio_oe_o, out_valid_o;
  wire         decimation_filter_valid_o, global_pdn_o, adc_a_pdn_o, adc_b_pdn_o;
  wire         refamp_pdn_o, clkbuf_pdn_o, single_ended_clk_o;
  wire [17:0]  out_a_o, out_b_o, decimation_filter_o;
  wire [5:0]   driver_pdn_o;
  wire [1:0]   ref_mode_o;
  int          n_errors = 0;
  int          n_checks = 0;
  scpd_top u_scpd_top (.*);
  scpd_ctrl_model u_scpd_ctrl_model (
    .select_n_o  (serial_select_n_i),
    .sclk_o      (sclk_i),
    .sdio_line_o (sdio_i),
    .dev_sdio_i  (sdio_o),
    .dev_oe_i    (sdio_oe_o)
  );
  // ---
  // helpers
  // ---
  function automatic logic [17:0] exp_a(input logic [17:0] a, b, input logic avg);
    logic [18:0] s;
    s = {a[17], a} + {b[17], b};
    return avg ? s[18:1] : a;
  endfunction
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic complete_run;
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] want);
    n_checks++;
    if (got !== want) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic frame(input logic [23:0] w);
    u_scpd_ctrl_model.sel(1'b0);
    u_scpd_ctrl_model.shift(w, 24, rd);
    u_scpd_ctrl_model.sel(1'b1);
  endtask
  task automatic rchk(input logic [14:0] a, input logic [7:0] v);
    frame({1'b1, a, 8'hA5});
    chk(18'(rd), 18'(v));
  endtask
  task automatic dchk(input logic avg, input logic filt);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end while (out_valid_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      complete_run();
    end
    chk(filt ? decimation_filter_o : out_a_o, exp_a(pa, pb, avg));
    chk(18'(decimation_filter_valid_o), 18'h1);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    lf <= lfsr_next(lf);
    ch_a_i <= {lf[1:0], lf};
    ch_b_i <= {lf[15:14], ~lf};
    sample_valid_i <= lf[0];
    pa <= ch_a_i;
    pb <= ch_b_i;
  end
  initial begin
    {rst_n_i, powerdown_sync_pin_i, sample_valid_i, ch_a_i, ch_b_i} = '0;
    {ce_i, sample_clk_present_i, reference_select_pin_i} = 4'hF;
    cyc(4);
    rst_n_i <= 1'b1;
    cyc(4);
    chk(18'(ref_mode_o), 18'h3);
    rchk(`SCPD_ADDR_PDN, `SCPD_RST_PDN);
    rchk(`SCPD_ADDR_AVG, `SCPD_RST_AVG);
    for (int c = 0; c < 4; c++) begin
      reference_select_pin_i <= 2'(c);
      cyc(6);
      chk(18'({single_ended_clk_o, ref_mode_o}), 18'(c == 0 ? 4 : c));
    end
    sample_clk_present_i <= 1'b0;
    powerdown_sync_pin_i <= 1'b1;
    cyc(8);
    chk(18'(global_pdn_o), 18'h0);
    sample_clk_present_i <= 1'b1;
    cyc(8);
    chk(18'({global_pdn_o, adc_a_pdn_o, adc_b_pdn_o}), 18'h7);
    powerdown_sync_pin_i <= 1'b0;
    u_scpd_ctrl_model.sel(1'b0);
    u_scpd_ctrl_model.shift({1'b0, `SCPD_ADDR_DRV, 8'h2A}, 24, rd);
    u_scpd_ctrl_model.shift({1'b0, `SCPD_ADDR_PDN, 8'h01}, 24, rd);
    u_scpd_ctrl_model.shift({1'b0, `SCPD_ADDR_DRV, 8'h15}, 23, rd);
    u_scpd_ctrl_model.sel(1'b1);
    u_scpd_ctrl_model.shift({1'b0, `SCPD_ADDR_DRV, 8'h07}, 24, rd);
    frame({1'b0, 15'h1009, 8'h3F});
    rchk(`SCPD_ADDR_DRV, 8'h2A);
    rchk(15'h0100, 8'h00);
    chk(18'({global_pdn_o, driver_pdn_o}), 18'h6A);
    frame({1'b0, `SCPD_ADDR_MASK, 8'h0C});
    cyc(4);
    chk(18'({refamp_pdn_o, clkbuf_pdn_o}), 18'h3);
    frame({1'b0, `SCPD_ADDR_PDN, 8'h00});
    dchk(1'b0, 1'b0);
    dchk(1'b0, 1'b1);
    frame({1'b0, `SCPD_ADDR_AVG, 8'h20});
    dchk(1'b1, 1'b0);
    frame({1'b0, `SCPD_ADDR_AVG, 8'h28});
    dchk(1'b1, 1'b1);
    chk(18'(global_pdn_o), 18'h0);
    chk(18'({refamp_pdn_o, clkbuf_pdn_o}), 18'h0);
    complete_run();
  end
endmodule
